/* core/arws_consts.vh */
/*
 * constants for the result word serializer: word layout, link sequence
 * counts, configuration prefix and buffer sizing.
 * assumes it is included by its bare name from the core/ design files.
 */
`ifndef ARWS_CONSTS_VH
`define ARWS_CONSTS_VH

// ****************************************************************
// word layout
// ****************************************************************
`define ARWS_WORD_BITS      32
`define ARWS_EOC_BIT        31
`define ARWS_DUMMY_BIT      30
`define ARWS_SIGN_BIT       29
`define ARWS_MSB_BIT        28
`define ARWS_LSB_BIT        5
`define ARWS_VALUE_BITS     30
`define ARWS_LOW_BITS       29
`define ARWS_EOC_BUSY       1'h1
`define ARWS_EOC_DONE       1'h0
`define ARWS_DUMMY_LEVEL    1'h0
`define ARWS_OVER_WORD      32'h30000000
`define ARWS_UNDER_WORD     32'h0fffffff
`define ARWS_WORD_ZERO      32'h00000000

// ****************************************************************
// link sequence
// ****************************************************************
`define ARWS_FALL_CNT_W     5
`define ARWS_FALL_LAST      5'h1f
`define ARWS_FALL_ZERO      5'h00
`define ARWS_FALL_ONE       5'h01

// ****************************************************************
// configuration word shifted in during data output
// ****************************************************************
`define ARWS_CFG_BITS       13
`define ARWS_CFG_CNT_W      4
`define ARWS_CFG_CNT_LAST   4'hc
`define ARWS_CFG_CNT_ZERO   4'h0
`define ARWS_CFG_CNT_ONE    4'h1
`define ARWS_CFG_PREFIX     3'h5
`define ARWS_CFG_FIELD_W    5
`define ARWS_CHAN           9:5
`define ARWS_SPD            4:0
`define ARWS_CFG_CHAN_RST   5'h00
`define ARWS_CFG_SPEED_RST  5'h00
`define ARWS_CFG_SPEED_KEEP 5'h00

// ****************************************************************
// result buffer
// ****************************************************************
`define ARWS_FIFO_WIDTH     32
`define ARWS_FIFO_DEPTH     16
`define ARWS_FIFO_AW        4
`define ARWS_SYNC_WIDTH     3
`define ARWS_SYNC_IDLE      3'h2

`endif

/* core/arws_sync.v */
/*
 * two flip-flop synchroniser for a group of independent levels.
 * assumes each bit is a slow level or a clock much slower than sys_clk.
 */
module arws_sync #(
    parameter             WIDTH   = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    input  wire             sys_clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage_one;

    // first stage feeds only the second stage; reset to idle levels
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stage_one <= RST_VAL;
            sync_out  <= RST_VAL;
        end else begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end

endmodule // arws_sync

/* core/arws_fifo.v */
/*
 * synchronous fifo with valid/ready on both sides and registered
 * full and empty indications.
 * assumes one clock; DEPTH is a power of two equal to 2**AW.
 */
module arws_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             sys_clk,
    input  wire             rst,
    input  wire             in_valid,
    output reg              in_ready,
    input  wire [WIDTH-1:0] in_data,
    output reg              out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    reg [AW:0]      next_count;
    wire            do_push;
    wire            do_pop;

    assign do_push  = in_valid & in_ready;
    assign do_pop   = out_valid & out_ready;
    assign out_data = mem[rd_ptr];

    // occupancy after this cycle's push and pop
    always @* begin
        next_count = count;
        if (do_push & ~do_pop) begin
            next_count = count + {{AW{1'b0}}, 1'b1};
        end else if (do_pop & ~do_push) begin
            next_count = count - {{AW{1'b0}}, 1'b1};
        end
    end

    // storage is written without reset
    always @(posedge sys_clk) begin
        if (do_push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and registered flags
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_ptr    <= {AW{1'b0}};
            rd_ptr    <= {AW{1'b0}};
            count     <= {(AW+1){1'b0}};
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            count     <= next_count;
            in_ready  <= (next_count != DEPTH[AW:0]);
            out_valid <= (next_count != {(AW+1){1'b0}});
        end
    end

endmodule // arws_fifo

/* core/arws_serializer.v */
/*
 * result word serializer: builds the 32-bit status/result word from
 * modulator results, buffers it, and shifts it out on the serial link
 * under a host-driven serial clock and active-low chip select. also
 * captures the configuration word shifted in during data output.
 * assumes sys_clk runs several times faster than the serial clock, and
 * that the host keeps its own side of the link sequence.
 */
// Overview of operation
// - every result leaves as exactly 32 bits
// - bits 28..5 result, 4..0 sub-LSBs
// - bit 31 high converting, low when done
// - bit 30 is always low
// - bit 29 high for zero or positive
// - 29,28 both high over, both low under
// - out of range clamps to limits plus/minus one
// - in range: sign then offset binary value
// - chip select high: output off, clock ignored
// - select low shows end flag, live update
// - bit 31 before first rise, then falling shifts
// - bit 0 leaves on 31st falling edge
// - 32nd falling edge drives output high
// - status only outside output; config during output
// - output ends after 32 bits or select high
// - select rising in output aborts, new conversion
`include "arws_consts.vh"

module arws_serializer (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        serial_clock,
    input  wire        chip_select_n,
    input  wire        serial_config_in,
    input  wire        sample_valid,
    output wire        sample_ready,
    input  wire [29:0] sample_value,
    input  wire        sample_over,
    input  wire        sample_under,
    output reg         conv_start,
    output reg         conv_busy,
    output reg         serial_result_out,
    output reg         serial_result_oe,
    output reg         cfg_update,
    output reg  [4:0]  cfg_channel,
    output reg  [4:0]  cfg_speed
);

    // ****************************************************************
    // states
    // ****************************************************************
    localparam [2:0] ST_CONV  = 3'h1;
    localparam [2:0] ST_SLEEP = 3'h2;
    localparam [2:0] ST_OUT   = 3'h4;

    // ****************************************************************
    // declarations
    // ****************************************************************
    wire [`ARWS_SYNC_WIDTH-1:0] pins_sync;
    wire                        sck_s;
    wire                        cs_n_s;
    wire                        sdi_s;
    reg                         sck_d;
    reg                         cs_n_d;
    wire                        sck_rise;
    wire                        sck_fall;
    wire                        cs_rise;

    reg  [`ARWS_FIFO_WIDTH-1:0] enc_word;
    wire [`ARWS_FIFO_WIDTH-1:0] buf_word;
    wire                        buf_valid;
    wire                        buf_pop;

    reg  [2:0]                  state;
    reg  [2:0]                  next_state;
    reg                         started;
    reg  [`ARWS_WORD_BITS-1:0]  shift_word;
    reg  [`ARWS_FALL_CNT_W-1:0] fall_cnt;
    reg                         next_sdo;

    reg  [`ARWS_CFG_BITS-1:0]   cfg_shift;
    reg  [`ARWS_CFG_CNT_W-1:0]  cfg_cnt;
    reg                         cfg_done;
    wire [`ARWS_CFG_BITS-1:0]   cfg_full;

    // ****************************************************************
    // pin synchronisers and edge detection
    // ****************************************************************
    arws_sync #(
        .WIDTH    (`ARWS_SYNC_WIDTH),
        .RST_VAL  (`ARWS_SYNC_IDLE)
    ) u_pin_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in ({serial_config_in, chip_select_n, serial_clock}),
        .sync_out (pins_sync)
    );

    assign sck_s  = pins_sync[0];
    assign cs_n_s = pins_sync[1];
    assign sdi_s  = pins_sync[2];

    // previous synchronised levels; select idles high
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sck_d  <= 1'b0;
            cs_n_d <= 1'b1;
        end else begin
            sck_d  <= sck_s;
            cs_n_d <= cs_n_s;
        end
    end

    // clock edges only count while selected
    assign sck_rise = sck_s & ~sck_d & ~cs_n_s;
    assign sck_fall = ~sck_s & sck_d & ~cs_n_s;
    assign cs_rise  = cs_n_s & ~cs_n_d;

    // ****************************************************************
    // result encoding ahead of the buffer
    // ****************************************************************
    // value is 30-bit two's complement: 24 result bits plus 5 sub-LSBs
    // below the sign; anything that does not fit clamps
    always @* begin
        enc_word = `ARWS_WORD_ZERO;
        if (sample_over |
            (~sample_value[`ARWS_SIGN_BIT] &
             sample_value[`ARWS_MSB_BIT])) begin
            enc_word = `ARWS_OVER_WORD;
        end else if (sample_under |
                     (sample_value[`ARWS_SIGN_BIT] &
                      ~sample_value[`ARWS_MSB_BIT])) begin
            enc_word = `ARWS_UNDER_WORD;
        end else begin
            // inverted top bit makes sign-then-offset-binary
            enc_word[`ARWS_SIGN_BIT] =
                ~sample_value[`ARWS_SIGN_BIT];
            enc_word[`ARWS_LOW_BITS-1:0] =
                sample_value[`ARWS_LOW_BITS-1:0];
        end
        enc_word[`ARWS_EOC_BIT]   = `ARWS_EOC_DONE;
        enc_word[`ARWS_DUMMY_BIT] = `ARWS_DUMMY_LEVEL;
    end

    // ****************************************************************
    // result buffer
    // ****************************************************************
    arws_fifo #(
        .WIDTH     (`ARWS_FIFO_WIDTH),
        .DEPTH     (`ARWS_FIFO_DEPTH),
        .AW        (`ARWS_FIFO_AW)
    ) u_result_fifo (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_valid  (sample_valid),
        .in_ready  (sample_ready),
        .in_data   (enc_word),
        .out_valid (buf_valid),
        .out_ready (buf_pop),
        .out_data  (buf_word)
    );

    // a result is taken only by a running conversion, so the buffer
    // fills while the host leaves the word unread
    assign buf_pop = buf_valid & started & (state == ST_CONV);

    // ****************************************************************
    // conversion / sleep / data output sequencer
    // ****************************************************************
    always @* begin
        next_state = state;
        case (state)
            ST_CONV: begin
                if (buf_pop) begin
                    next_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                // data output opens on first selected rising clock
                if (sck_rise) begin
                    next_state = ST_OUT;
                end
            end
            ST_OUT: begin
                if (cs_rise) begin
                    next_state = ST_CONV;
                end else if (sck_fall &&
                             fall_cnt == `ARWS_FALL_LAST) begin
                    next_state = ST_CONV;
                end
            end
            default: begin
                next_state = ST_CONV;
            end
        endcase
    end

    // state, word register and falling edge count
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state      <= ST_CONV;
            started    <= 1'b0;
            shift_word <= `ARWS_WORD_ZERO;
            fall_cnt   <= `ARWS_FALL_ZERO;
            conv_start <= 1'b0;
            conv_busy  <= 1'b1;
        end else begin
            state      <= next_state;
            conv_start <= 1'b0;
            conv_busy  <= (next_state == ST_CONV);
            if (state == ST_CONV) begin
                if (!started) begin
                    // one pulse per conversion to the modulator
                    conv_start <= 1'b1;
                    started    <= 1'b1;
                end
                if (buf_pop) begin
                    shift_word <= buf_word;
                    fall_cnt   <= `ARWS_FALL_ZERO;
                    started    <= 1'b0;
                end
            end else if (state == ST_OUT && next_state == ST_OUT &&
                         sck_fall) begin
                // next bit onto the line, MSB first
                shift_word <= {shift_word[`ARWS_WORD_BITS-2:0],
                               1'b0};
                fall_cnt   <= fall_cnt + `ARWS_FALL_ONE;
            end
        end
    end

    // ****************************************************************
    // serial output pin
    // ****************************************************************
    // converting shows busy; sleep and output show the word's top bit,
    // which in sleep is the low end flag
    always @* begin
        next_sdo = `ARWS_EOC_BUSY;
        case (state)
            ST_CONV: begin
                if (buf_pop) begin
                    next_sdo = buf_word[`ARWS_EOC_BIT];
                end
            end
            ST_SLEEP: begin
                next_sdo = shift_word[`ARWS_EOC_BIT];
            end
            ST_OUT: begin
                if (next_state == ST_CONV) begin
                    next_sdo = `ARWS_EOC_BUSY;
                end else if (sck_fall) begin
                    next_sdo = shift_word[`ARWS_EOC_BIT-1];
                end else begin
                    next_sdo = shift_word[`ARWS_EOC_BIT];
                end
            end
            default: begin
                next_sdo = `ARWS_EOC_BUSY;
            end
        endcase
    end

    // pin driver only enabled while selected
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            serial_result_out <= `ARWS_EOC_BUSY;
            serial_result_oe  <= 1'b0;
        end else begin
            serial_result_out <= next_sdo;
            serial_result_oe  <= ~cs_n_s;
        end
    end

    // ****************************************************************
    // configuration capture during data output
    // ****************************************************************
    assign cfg_full = {cfg_shift[`ARWS_CFG_BITS-2:0], sdi_s};

    // sample on rising edges, only inside the data output state; the
    // first selected rise also opens that state and carries bit one
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg_shift   <= {`ARWS_CFG_BITS{1'b0}};
            cfg_cnt     <= `ARWS_CFG_CNT_ZERO;
            cfg_done    <= 1'b0;
            cfg_update  <= 1'b0;
            cfg_channel <= `ARWS_CFG_CHAN_RST;
            cfg_speed   <= `ARWS_CFG_SPEED_RST;
        end else begin
            cfg_update <= 1'b0;
            if (state == ST_CONV) begin
                cfg_cnt  <= `ARWS_CFG_CNT_ZERO;
                cfg_done <= 1'b0;
            end else if (sck_rise && !cfg_done &&
                         (state == ST_OUT || state == ST_SLEEP)) begin
                cfg_shift <= cfg_full;
                if (cfg_cnt == `ARWS_CFG_CNT_LAST) begin
                    cfg_done <= 1'b1;
                    // only the update prefix changes the settings
                    if (cfg_full[`ARWS_CFG_BITS-1:`ARWS_CFG_BITS-3] ==
                        `ARWS_CFG_PREFIX) begin
                        cfg_update  <= 1'b1;
                        cfg_channel <= cfg_full[`ARWS_CHAN];
                        if (cfg_full[`ARWS_SPD] != `ARWS_CFG_SPEED_KEEP) begin
                            cfg_speed <= cfg_full[`ARWS_SPD];
                        end
                    end
                end else begin
                    cfg_cnt <= cfg_cnt + `ARWS_CFG_CNT_ONE;
                end
            end
        end
    end

endmodule // arws_serializer

/* sim/arws_chk.sv */
/* port checker for the result word serializer.
   assumes the serializer ports as declared; bound after the module. */
module arws_chk (
    input wire        sys_clk,
    input wire        rst,
    input wire        serial_clock,
    input wire        chip_select_n,
    input wire        serial_config_in,
    input wire        sample_valid,
    input wire        sample_ready,
    input wire [29:0] sample_value,
    input wire        sample_over,
    input wire        sample_under,
    input wire        conv_start,
    input wire        conv_busy,
    input wire        serial_result_out,
    input wire        serial_result_oe,
    input wire        cfg_update,
    input wire [4:0]  cfg_channel,
    input wire [4:0]  cfg_speed
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // ****************************************************************
    // link sequences
    // ****************************************************************
    sequence s_conv_done;
        conv_busy ##1 !conv_busy;
    endsequence
    sequence s_held_off;
        chip_select_n [*8];
    endsequence

    a_oe_off_deselected: assert property (
        chip_select_n [*4] |-> !serial_result_oe)
        else $error("output driven while deselected");
    a_oe_on_selected: assert property (
        !chip_select_n [*5] |-> serial_result_oe)
        else $error("output off while selected");
    a_clock_ignored: assert property (
        s_held_off |-> !conv_start && !cfg_update)
        else $error("link activity while deselected");
    a_start_one_cycle: assert property (conv_start |=> !conv_start)
        else $error("start pulse too long");
    a_start_sets_busy: assert property (
        conv_start |-> ##[0:1] conv_busy)
        else $error("start without conversion");
    a_busy_shows_high: assert property (
        conv_busy && $past(conv_busy) && serial_result_oe
        |-> serial_result_out)
        else $error("end flag low while converting");
    a_done_shows_low: assert property (
        s_conv_done ##0 serial_result_oe |-> !serial_result_out)
        else $error("end flag not low at completion");
    a_cfg_one_cycle: assert property (cfg_update |=> !cfg_update)
        else $error("config pulse too long");
    a_cfg_needs_pulse: assert property (
        $changed(cfg_channel) || $changed(cfg_speed) |-> cfg_update)
        else $error("config changed without update");
endmodule // arws_chk

bind arws_serializer arws_chk i_arws_chk (
    .sys_clk(sys_clk), .rst(rst), .serial_clock(serial_clock),
    .chip_select_n(chip_select_n), .serial_config_in(serial_config_in),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample_value(sample_value), .sample_over(sample_over),
    .sample_under(sample_under), .conv_start(conv_start),
    .conv_busy(conv_busy), .serial_result_out(serial_result_out),
    .serial_result_oe(serial_result_oe), .cfg_update(cfg_update),
    .cfg_channel(cfg_channel), .cfg_speed(cfg_speed)
);

/* sim/arws_host_model.sv */
/* host model: drives select, serial clock and config line, reads words.
   assumes pin is the resolved result line and sys_clk the bench clock. */
module arws_host_model (
    input  wire  sys_clk,
    input  wire  pin,
    output logic serial_clock,
    output logic chip_select_n,
    output logic serial_config_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hi;

    // idle: deselected, clock parked low
    initial begin
        serial_clock = 1'b0;
        chip_select_n = 1'b1;
        serial_config_in = 1'b0;
        hi = 1'b0;
    end

    // wait whole cycles, noting any high level on the line
    task automatic tick(input int k);
        repeat (k) begin
            @(posedge sys_clk);
            #2;
            if (pin === 1'b1) hi = 1'b1;
        end
    endtask

    // toggle the clock while deselected
    task automatic stray(input int k);
        repeat (k) begin
            serial_clock = ~serial_clock;
            tick(4);
        end
    endtask

    // one frame: select, wait for the end flag, n clocks, maybe release
    task automatic frame(input int n, input int half, input logic [12:0] cfg,
                         input bit rel, output logic [31:0] w,
                         output logic eoc, output logic done_hi);
        int t;
        t = 0;
        chip_select_n = 1'b0;
        serial_config_in = cfg[12];
        tick(4);
        while (pin !== 1'b0 && t < 400) begin
            tick(1);
            t++;
        end
        eoc = pin;
        w = 32'h0;
        for (int i = 0; i < n; i++) begin
            tick(half);
            serial_clock = 1'b1;
            w[31-i] = pin;
            tick(half);
            serial_clock = 1'b0;
            if (i < 12) serial_config_in = cfg[11-i];
        end
        repeat (3) @(posedge sys_clk);
        hi = 1'b0;
        tick(9);
        done_hi = hi;
        if (rel) begin
            chip_select_n = 1'b1;
            serial_config_in = ~serial_config_in;
            tick(8);
        end
    endtask
endmodule // arws_host_model

/* sim/tb.sv */
/* self-checking bench for the result word serializer.
   assumes the host model on the link and the bound port checker. */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, rst, serial_clock, chip_select_n, serial_config_in;
    logic        sample_valid, sample_over, sample_under, e, h, acc;
    logic [29:0] sample_value;
    logic [29:0] val [17];
    logic        ovr [17];
    logic        und [17];
    logic [31:0] w;
    logic [12:0] cw;
    wire         sample_ready, conv_start, conv_busy, cfg_update;
    wire         serial_result_out, serial_result_oe;
    wire  [4:0]  cfg_channel, cfg_speed;
    wire         pin = serial_result_oe ? serial_result_out : 1'bz;
    int          num_errors = 0, num_checks = 0;
    int          cyc = 0, starts = 0, ups = 0, n, s0;

    arws_serializer i_arws_serializer (
        .sys_clk(sys_clk), .rst(rst), .serial_clock(serial_clock),
        .chip_select_n(chip_select_n), .serial_config_in(serial_config_in),
        .sample_valid(sample_valid), .sample_ready(sample_ready),
        .sample_value(sample_value), .sample_over(sample_over),
        .sample_under(sample_under), .conv_start(conv_start),
        .conv_busy(conv_busy), .serial_result_out(serial_result_out),
        .serial_result_oe(serial_result_oe), .cfg_update(cfg_update),
        .cfg_channel(cfg_channel), .cfg_speed(cfg_speed)
    );

    arws_host_model i_arws_host_model (
        .sys_clk(sys_clk), .pin(pin), .serial_clock(serial_clock),
        .chip_select_n(chip_select_n), .serial_config_in(serial_config_in)
    );

    // expected word: clamps first, else sign then offset binary
    function automatic logic [31:0] expw(input logic [29:0] v,
                                         input logic o, input logic u);
        if (o || v[29:28] == 2'h1) return 32'h30000000;
        if (u || v[29:28] == 2'h2) return 32'h0fffffff;
        return {2'h0, ~v[29], v[28:0]};
    endfunction

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude;
        if (num_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // pulse counters and hang limit
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (conv_start === 1'b1) starts <= starts + 1;
        if (cfg_update === 1'b1) ups <= ups + 1;
        if (cyc == 20000) begin
            num_errors++;
            conclude();
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        rst = 1'b1;
        sample_valid = 1'b0;
        sample_value = 30'h0;
        sample_over = 1'b0;
        sample_under = 1'b0;
        for (int k = 0; k < 17; k++) begin
            val[k] = {3'h0, k[4:0], 22'h2a5a5a};
            ovr[k] = 1'b0;
            und[k] = 1'b0;
        end
        val[1] = 30'h3fffffff;
        val[2] = 30'h0fffffff;
        val[3] = 30'h30000000;
        val[7] = 30'h08000000;
        val[8] = 30'h37ffffff;
        val[10] = 30'h10000000;
        val[11] = 30'h20000000;
        ovr[4] = 1'b1;
        und[6] = 1'b1;
        ovr[9] = 1'b1;
        und[9] = 1'b1;
        repeat (20) @(posedge sys_clk);
        #2 rst = 1'b0;
        tick_free: repeat (4) @(posedge sys_clk);
        #2;
        check("oe idle", serial_result_oe, 1'b0);
        n = 0;
        for (int c = 0; c < 60; c++) begin
            sample_valid = 1'b1;
            sample_value = val[n > 16 ? 16 : n];
            sample_over = ovr[n > 16 ? 16 : n];
            sample_under = und[n > 16 ? 16 : n];
            acc = (sample_ready === 1'b1);
            @(posedge sys_clk);
            #2;
            if (acc) n++;
        end
        sample_valid = 1'b0;
        check("accepted", n, 17);
        check("ready full", sample_ready, 1'b0);
        for (int k = 0; k < 17; k++) begin
            if (k == 8) begin
                s0 = starts;
                i_arws_host_model.frame(0, 4, 13'h0, 1'b1, w, e, h);
                i_arws_host_model.stray(6);
                check("sleep starts", starts - s0, 0);
            end
            cw = k == 0 ? 13'h14cb : k == 1 ? 13'h1460 :
                 k == 2 ? 13'h13ff : 13'h03ff;
            s0 = starts;
            i_arws_host_model.frame(k == 5 ? 10 : 32, 4, cw,
                                    k == 5, w, e, h);
            check("end flag", e, 1'b0);
            check("starts", starts - s0, 1);
            check("channel", cfg_channel, k == 0 ? 5'h06 : 5'h03);
            check("speed", cfg_speed, 5'h0b);
            check("updates", ups, k == 0 ? 1 : 2);
            if (k == 5) begin
                check("oe abort", serial_result_oe, 1'b0);
            end else begin
                check("word", w,
                      expw(val[k], ovr[k], und[k]));
                check("start mark", h, 1'b1);
            end
        end
        repeat (30) @(posedge sys_clk);
        #2;
        check("flag busy", pin, 1'b1);
        check("busy", conv_busy, 1'b1);
        check("ready empty", sample_ready, 1'b1);
        conclude();
    end
endmodule // tb
